// ===== patm_pkg.sv
/*
 * Constants for the PCI address trap monitor: register offsets, reset
 * values, writable-bit masks and PCI command encodings.
 * Assumes configuration offsets are byte addresses of aligned dwords.
 */
package patm_pkg;

    localparam int NREG = 17;

    // Register indices into the bank.
    localparam int R_PM_IO_SPACE_POINTER   = 0;
    localparam int R_CLASS_CODE_OVERRIDE   = 1;
    localparam int R_SERIAL_TRAP_ADDRESS   = 2;
    localparam int R_SERIAL_TRAP_MASK      = 3;
    localparam int R_AUDIO_TRAP_ADDR_LOW   = 4;
    localparam int R_AUDIO_TRAP_ADDR_HIGH  = 5;
    localparam int R_AUDIO_TRAP_MASK       = 6;
    localparam int R_CARD_TRAP_IO_ADDRESS  = 7;
    localparam int R_CARD_TRAP1_MEM_ADDR   = 8;
    localparam int R_CARD_TRAP2_MEM_ADDR   = 9;
    localparam int R_CARD_TRAP_MASK        = 10;
    localparam int R_IO_RANGE_ADDR_LOW     = 11;
    localparam int R_IO_RANGE_ADDR_HIGH    = 12;
    localparam int R_IO_RANGE_MASK         = 13;
    localparam int R_MEM_RANGE1_ADDRESS    = 14;
    localparam int R_MEM_RANGE2_ADDRESS    = 15;
    localparam int R_MEM_RANGE_MASK        = 16;

    localparam logic [7:0] REG_OFF [NREG] = '{
        8'h58, 8'h60, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0, 8'hb4, 8'hb8,
        8'hbc, 8'hc0, 8'hc4, 8'hc8, 8'hcc, 8'hd0, 8'hd4, 8'hd8};

    localparam logic [31:0] REG_RST [NREG] = '{
        32'h0000dd01, 32'h00000000, 32'h02f803f8, 32'h00000f0f,
        32'h03300220, 32'h03880530, 32'h0707010f, 32'h00000000,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h00000000};

    // Bits software may change; all others hold their reset value.
    localparam logic [31:0] REG_WMASK [NREG] = '{
        32'h0000ff00, 32'hffffff00, 32'hffffffff, 32'h0000ffff,
        32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        32'hfffffc00, 32'hfffffc00, 32'hffffffff, 32'hffffffff,
        32'hffffffff, 32'hffffffff, 32'hffffff00, 32'hffffff00,
        32'hffffffff};

    // PCI bus commands seen on C/BE during the address phase.
    localparam logic [3:0] CMD_IO_READ    = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE   = 4'h3;
    localparam logic [3:0] CMD_MEM_READ   = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE  = 4'h7;
    localparam logic [3:0] CMD_MEM_RDMULT = 4'hc;
    localparam logic [3:0] CMD_MEM_RDLINE = 4'he;
    localparam logic [3:0] CMD_MEM_WRINV  = 4'hf;

endpackage

// ===== patm_top.sv
/*
 * Configuration register bank and address-phase snoop comparators that
 * raise trap events, claim the system-management IO window and supply
 * the class-code override to the configuration header.
 * Assumes the PCI address phase and configuration accesses are already
 * decoded to one-cycle strobes synchronous to SYS_CLK.
 */
module patm_top
    import patm_pkg::*;
(
    // Clock and reset.
    input  wire logic        SYS_CLK,
    input  wire logic        RSTN,
    // Configuration access port.
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [3:0]  CFG_BE,
    input  wire logic [31:0] CFG_WDATA,
    output logic      [31:0] CFG_RDATA,
    output logic             CFG_RVALID,
    // PCI address phase snoop.
    input  wire logic        PCI_ADDR_PHASE,
    input  wire logic [31:0] PCI_AD,
    input  wire logic [3:0]  PCI_CMD,
    // Control bits held elsewhere.
    input  wire logic        SYSMGMT_IO_DECODE_ENABLE,
    input  wire logic        RANGE3_MASK_EXTEND,
    input  wire logic        RANGE4_MASK_EXTEND,
    // Results.
    output logic      [23:0] HEADER_CLASS_FIELD,
    output logic             SYSMGMT_IO_HIT,
    output logic      [1:0]  SERIAL_TRAP_EVENT,
    output logic             AUDIO_TRAP_EVENT,
    output logic      [1:0]  CARD_TRAP_EVENT,
    output logic      [3:0]  IO_RANGE_EVENT,
    output logic      [1:0]  MEM_RANGE_EVENT
);
    import patm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Comparison helpers.

    // Masked IO compare; ext forces bits 10:8 into the mask as well.
    function automatic logic io_match(input logic [15:0] ad, input logic [15:0] cmp,
                                      input logic [7:0] mask, input logic ext);
        logic [15:0] m;
        m = {5'h0, {3{ext}}, mask};
        return (ad | m) == (cmp | m);
    endfunction

    function automatic logic is_io(input logic [3:0] cmd);
        return (cmd == CMD_IO_READ) || (cmd == CMD_IO_WRITE);
    endfunction

    function automatic logic is_mem(input logic [3:0] cmd);
        return (cmd == CMD_MEM_READ) || (cmd == CMD_MEM_WRITE) ||
               (cmd == CMD_MEM_RDMULT) || (cmd == CMD_MEM_RDLINE) ||
               (cmd == CMD_MEM_WRINV);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register bank.

    logic [31:0] regs_reg [NREG];
    logic [31:0] rd_chain [NREG+1];
    logic [31:0] be_mask;

    assign be_mask = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
    assign rd_chain[0] = 32'h00000000;

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            logic        sel;
            logic [31:0] wr_bits;
            assign sel     = CFG_ADDR[7:2] == REG_OFF[gi][7:2];
            // Read-only and reserved bits never take write data.
            assign wr_bits = be_mask & REG_WMASK[gi];
            assign rd_chain[gi+1] = rd_chain[gi] | (sel ? regs_reg[gi] : 32'h00000000);
            always_ff @(posedge SYS_CLK) begin
                if (!RSTN) begin
                    regs_reg[gi] <= REG_RST[gi];
                end else if (CFG_WR && sel) begin
                    regs_reg[gi] <= (regs_reg[gi] & ~wr_bits) | (CFG_WDATA & wr_bits);
                end
            end
        end
    endgenerate

    // Unmapped offsets fall through the chain and read as zero.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            CFG_RDATA  <= 32'h00000000;
            CFG_RVALID <= 1'b0;
        end else begin
            CFG_RDATA  <= CFG_RD ? rd_chain[NREG] : 32'h00000000;
            CFG_RVALID <= CFG_RD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field extraction.

    logic [7:0]  sysmgmt_io_base;
    logic [31:0] serial_addr;
    logic [15:0] serial_mask;
    logic [15:0] audio_port_address [4];
    logic [31:0] audio_port_masks;
    logic [15:0] card_io_address [2];
    logic [21:0] card_mem_address [2];
    logic [31:0] card_masks;
    logic [15:0] io_range_address [4];
    logic [31:0] io_range_masks;
    logic [23:0] mem_range_address [2];
    logic [31:0] mem_range_masks;

    assign sysmgmt_io_base       = regs_reg[R_PM_IO_SPACE_POINTER][15:8];
    assign serial_addr           = regs_reg[R_SERIAL_TRAP_ADDRESS];
    assign serial_mask           = regs_reg[R_SERIAL_TRAP_MASK][15:0];
    assign audio_port_address[0] = regs_reg[R_AUDIO_TRAP_ADDR_LOW][15:0];
    assign audio_port_address[1] = regs_reg[R_AUDIO_TRAP_ADDR_LOW][31:16];
    assign audio_port_address[2] = regs_reg[R_AUDIO_TRAP_ADDR_HIGH][15:0];
    assign audio_port_address[3] = regs_reg[R_AUDIO_TRAP_ADDR_HIGH][31:16];
    assign audio_port_masks      = regs_reg[R_AUDIO_TRAP_MASK];
    assign card_io_address[0]    = regs_reg[R_CARD_TRAP_IO_ADDRESS][15:0];
    assign card_io_address[1]    = regs_reg[R_CARD_TRAP_IO_ADDRESS][31:16];
    assign card_mem_address[0]   = regs_reg[R_CARD_TRAP1_MEM_ADDR][31:10];
    assign card_mem_address[1]   = regs_reg[R_CARD_TRAP2_MEM_ADDR][31:10];
    assign card_masks            = regs_reg[R_CARD_TRAP_MASK];
    assign io_range_address[0]   = regs_reg[R_IO_RANGE_ADDR_LOW][15:0];
    assign io_range_address[1]   = regs_reg[R_IO_RANGE_ADDR_LOW][31:16];
    assign io_range_address[2]   = regs_reg[R_IO_RANGE_ADDR_HIGH][15:0];
    assign io_range_address[3]   = regs_reg[R_IO_RANGE_ADDR_HIGH][31:16];
    assign io_range_masks        = regs_reg[R_IO_RANGE_MASK];
    assign mem_range_address[0]  = regs_reg[R_MEM_RANGE1_ADDRESS][31:8];
    assign mem_range_address[1]  = regs_reg[R_MEM_RANGE2_ADDRESS][31:8];
    assign mem_range_masks       = regs_reg[R_MEM_RANGE_MASK];

    ////////////////////////////////////////////////////////////////////////
    // Snoop comparators. No target decode gates them, so cycles aimed at
    // other agents trap too.

    logic       io_phase;
    logic       mem_phase;
    logic [1:0] serial_hit;
    logic [3:0] audio_hit;
    logic [1:0] card_hit;
    logic [3:0] io_range_hit;
    logic [1:0] mem_range_hit;
    logic [3:0] range_ext;
    logic       sysmgmt_hit;

    assign io_phase  = PCI_ADDR_PHASE && is_io(PCI_CMD);
    assign mem_phase = PCI_ADDR_PHASE && is_mem(PCI_CMD);
    assign range_ext = {RANGE4_MASK_EXTEND, RANGE3_MASK_EXTEND, 2'b00};

    // Upper address must be zero: IO space is only 64 KiB wide.
    assign sysmgmt_hit = io_phase && SYSMGMT_IO_DECODE_ENABLE &&
                         (PCI_AD[31:16] == 16'h0000) &&
                         (PCI_AD[15:8] == sysmgmt_io_base);

    generate
        for (gi = 0; gi < 2; gi++) begin : g_pair
            logic [21:0] cm;
            logic [23:0] mm;
            assign serial_hit[gi] = io_phase && io_match(PCI_AD[15:0],
                serial_addr[16*gi +: 16], serial_mask[8*gi +: 8], 1'b0);
            assign cm = {14'h0, card_masks[16+8*gi +: 8]};
            assign card_hit[gi] = (io_phase && io_match(PCI_AD[15:0],
                    card_io_address[gi], card_masks[8*gi +: 8], 1'b0)) ||
                (mem_phase && ((PCI_AD[31:10] | cm) ==
                    (card_mem_address[gi] | cm)));
            assign mm = {8'h00, mem_range_masks[16*gi +: 16]};
            assign mem_range_hit[gi] = mem_phase &&
                ((PCI_AD[31:8] | mm) == (mem_range_address[gi] | mm));
        end
        for (gi = 0; gi < 4; gi++) begin : g_quad
            assign audio_hit[gi] = io_phase && io_match(PCI_AD[15:0],
                audio_port_address[gi], audio_port_masks[8*gi +: 8], 1'b0);
            assign io_range_hit[gi] = io_phase && io_match(PCI_AD[15:0],
                io_range_address[gi], io_range_masks[8*gi +: 8], range_ext[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs. Each address phase is a one-cycle strobe, so the
    // events come out as single-cycle pulses one edge later.

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            HEADER_CLASS_FIELD <= 24'h000000;
            SYSMGMT_IO_HIT     <= 1'b0;
            SERIAL_TRAP_EVENT  <= 2'b00;
            AUDIO_TRAP_EVENT   <= 1'b0;
            CARD_TRAP_EVENT    <= 2'b00;
            IO_RANGE_EVENT     <= 4'h0;
            MEM_RANGE_EVENT    <= 2'b00;
        end else begin
            HEADER_CLASS_FIELD <= regs_reg[R_CLASS_CODE_OVERRIDE][31:8];
            SYSMGMT_IO_HIT     <= sysmgmt_hit;
            SERIAL_TRAP_EVENT  <= serial_hit;
            AUDIO_TRAP_EVENT   <= |audio_hit;
            CARD_TRAP_EVENT    <= card_hit;
            IO_RANGE_EVENT     <= io_range_hit;
            MEM_RANGE_EVENT    <= mem_range_hit;
        end
    end

endmodule

// ===== patm_top_asserts.sv
/* Port checker for the trap monitor.
   Assumes it is bound to patm_top and sees only its ports. */
module patm_top_asserts
    import patm_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RSTN,
    input wire logic        CFG_RD,
    input wire logic        CFG_RVALID,
    input wire logic [31:0] CFG_RDATA,
    input wire logic        PCI_ADDR_PHASE,
    input wire logic [31:0] PCI_AD,
    input wire logic [3:0]  PCI_CMD,
    input wire logic        SYSMGMT_IO_DECODE_ENABLE,
    input wire logic        SYSMGMT_IO_HIT,
    input wire logic [1:0]  SERIAL_TRAP_EVENT,
    input wire logic        AUDIO_TRAP_EVENT,
    input wire logic [1:0]  CARD_TRAP_EVENT,
    input wire logic [3:0]  IO_RANGE_EVENT,
    input wire logic [1:0]  MEM_RANGE_EVENT
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic io_cmd = PCI_CMD inside {CMD_IO_READ, CMD_IO_WRITE};
    wire logic mem_cmd = PCI_CMD inside {CMD_MEM_READ, CMD_MEM_WRITE, CMD_MEM_RDMULT,
                                         CMD_MEM_RDLINE, CMD_MEM_WRINV};
    wire logic io_ev = |{SERIAL_TRAP_EVENT, AUDIO_TRAP_EVENT, IO_RANGE_EVENT, SYSMGMT_IO_HIT};
    wire logic any_ev = io_ev | (|{CARD_TRAP_EVENT, MEM_RANGE_EVENT});
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    property p_rd_answer; CFG_RD |=> CFG_RVALID; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_idle; !CFG_RD |=> !CFG_RVALID && CFG_RDATA == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_ev_pulse; !PCI_ADDR_PHASE |=> !any_ev; endproperty
    a_ev_pulse: assert property (p_ev_pulse) else $error("event without phase");
    property p_io_space; PCI_ADDR_PHASE && !io_cmd |=> !io_ev; endproperty
    a_io_space: assert property (p_io_space) else $error("io trap on non-io");
    property p_mem_space; PCI_ADDR_PHASE && !mem_cmd |=> MEM_RANGE_EVENT == 2'h0; endproperty
    a_mem_space: assert property (p_mem_space) else $error("mem trap on non-mem");
    property p_card_space; !(io_cmd || mem_cmd) |=> CARD_TRAP_EVENT == 2'h0; endproperty
    a_card_space: assert property (p_card_space) else $error("card trap bad cmd");
    property p_mgmt_en; !SYSMGMT_IO_DECODE_ENABLE |=> !SYSMGMT_IO_HIT; endproperty
    a_mgmt_en: assert property (p_mgmt_en) else $error("window claimed while off");
    property p_mgmt_hi;
        SYSMGMT_IO_HIT |-> $past(PCI_ADDR_PHASE) && $past(PCI_AD[31:16]) == 16'h0;
    endproperty
    a_mgmt_hi: assert property (p_mgmt_hi) else $error("window hit above 64k");
    c_serial: cover property (SERIAL_TRAP_EVENT != 2'h0);
    c_mem: cover property (MEM_RANGE_EVENT != 2'h0);
    c_mgmt: cover property (SYSMGMT_IO_HIT);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind patm_top patm_top_asserts u_chk (.SYS_CLK, .RSTN, .CFG_RD, .CFG_RVALID, .CFG_RDATA,
    .PCI_ADDR_PHASE, .PCI_AD, .PCI_CMD, .SYSMGMT_IO_DECODE_ENABLE, .SYSMGMT_IO_HIT,
    .SERIAL_TRAP_EVENT, .AUDIO_TRAP_EVENT, .CARD_TRAP_EVENT, .IO_RANGE_EVENT, .MEM_RANGE_EVENT);

// ===== patm_pci_master.sv
/* Behavioural PCI master issuing one address phase per call.
   Assumes the caller runs in the same clock domain as the monitor. */
module patm_pci_master (
    input  wire logic        SYS_CLK,
    output logic             PCI_ADDR_PHASE,
    output logic      [31:0] PCI_AD,
    output logic      [3:0]  PCI_CMD
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        PCI_ADDR_PHASE = 1'b0;
        PCI_AD = 32'h0;
        PCI_CMD = 4'h1;
    end
    // Outside the phase the bus shows junk, so a stale address never matches by luck.
    task automatic phase(input logic [3:0] cmd, input logic [31:0] ad);
        @(posedge SYS_CLK);
        PCI_ADDR_PHASE <= 1'b1;
        PCI_CMD <= cmd;
        PCI_AD <= ad;
        @(posedge SYS_CLK);
        PCI_ADDR_PHASE <= 1'b0;
        PCI_CMD <= 4'h1;
        PCI_AD <= ~ad;
    endtask
endmodule

// ===== patm_top_tb.sv
/* Self-checking bench: random register traffic and snooped address phases
   compared with a shadow model. Assumes patm_pkg and the partner master. */
module patm_top_tb import patm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK = 0, RSTN = 0, CFG_WR = 0, CFG_RD = 0, en = 0, x3 = 0, x4 = 0;
    logic [7:0]  CFG_ADDR = 0;
    logic [3:0]  CFG_BE = 0, PCI_CMD;
    logic [31:0] CFG_WDATA = 0, CFG_RDATA, PCI_AD, a, r, d, m [NREG];
    logic        CFG_RVALID, PCI_ADDR_PHASE, SYSMGMT_IO_HIT, AUDIO_TRAP_EVENT;
    logic [23:0] HEADER_CLASS_FIELD;
    logic [1:0]  SERIAL_TRAP_EVENT, CARD_TRAP_EVENT, MEM_RANGE_EVENT;
    logic [3:0]  IO_RANGE_EVENT;
    logic [3:0]  cmds [8] = '{CMD_IO_READ, CMD_IO_WRITE, CMD_MEM_READ, CMD_MEM_WRITE,
                              CMD_MEM_RDMULT, CMD_MEM_RDLINE, CMD_MEM_WRINV, 4'hb};
    logic [31:0] lf = 32'h8bb19078;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    patm_top u_dut (.SYS_CLK, .RSTN, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_BE, .CFG_WDATA,
        .CFG_RDATA, .CFG_RVALID, .PCI_ADDR_PHASE, .PCI_AD, .PCI_CMD,
        .SYSMGMT_IO_DECODE_ENABLE(en), .RANGE3_MASK_EXTEND(x3), .RANGE4_MASK_EXTEND(x4),
        .HEADER_CLASS_FIELD, .SYSMGMT_IO_HIT, .SERIAL_TRAP_EVENT, .AUDIO_TRAP_EVENT,
        .CARD_TRAP_EVENT, .IO_RANGE_EVENT, .MEM_RANGE_EVENT);
    patm_pci_master u_mst (.SYS_CLK, .PCI_ADDR_PHASE, .PCI_AD, .PCI_CMD);
    always #5 SYS_CLK = ~SYS_CLK;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function automatic bit h(logic [31:0] x, t, k);
        return (x | k) == (t | k);
    endfunction
    // Bits: window, serial 2:1, audio, card 2:1, io range 4:1, mem range 2:1.
    function automatic logic [11:0] exp_ev(logic [3:0] c, logic [31:0] ad);
        logic io, mm, xt;
        logic [11:0] e;
        io = c inside {CMD_IO_READ, CMD_IO_WRITE};
        mm = c inside {CMD_MEM_READ, CMD_MEM_WRITE, CMD_MEM_RDMULT, CMD_MEM_RDLINE,
                       CMD_MEM_WRINV};
        e = '0;
        for (int i = 0; i < 4; i++) begin
            xt = (i == 2 && x3) || (i == 3 && x4);
            if (i < 2) begin
                e[9+i] = io && h(ad[15:0], m[2][16*i+:16], m[3][8*i+:8]);
                e[6+i] = (io && h(ad[15:0], m[7][16*i+:16], m[10][8*i+:8]))
                      || (mm && h(ad[31:10], m[8+i][31:10], m[10][16+8*i+:8]));
                e[i] = mm && h(ad[31:8], m[14+i][31:8], m[16][16*i+:16]);
            end
            e[8] |= io && h(ad[15:0], m[4+i/2][16*(i%2)+:16], m[6][8*i+:8]);
            e[2+i] = io && h(ad[15:0], m[11+i/2][16*(i%2)+:16], {(xt ? 3'h7 : 3'h0),
                     m[13][8*i+:8]});
        end
        e[11] = io && en && ad[31:16] == 16'h0 && ad[15:8] == m[0][15:8];
        return e;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_ev(string n, logic [3:0] e, logic [3:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] o, logic [3:0] be, logic [31:0] dat);
        logic [31:0] wm;
        wm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        @(posedge SYS_CLK);
        {CFG_WR, CFG_ADDR, CFG_BE, CFG_WDATA} <= {1'b1, o, be, dat};
        for (int i = 0; i < NREG; i++)
            if (REG_OFF[i] == o) m[i] = (m[i] & ~(wm & REG_WMASK[i])) | (dat & wm & REG_WMASK[i]);
        @(posedge SYS_CLK);
        CFG_WR <= 1'b0;
    endtask
    task automatic rd(logic [7:0] o);
        logic [31:0] e;
        e = 32'h0;
        for (int i = 0; i < NREG; i++) if (REG_OFF[i] == o) e = m[i];
        @(posedge SYS_CLK);
        {CFG_RD, CFG_ADDR} <= {1'b1, o};
        @(posedge SYS_CLK);
        CFG_RD <= 1'b0;
        #1;
        chk("cfg_rdata", e, CFG_RDATA);
        chk("cfg_rvalid", 32'h1, {31'h0, CFG_RVALID});
        chk("class_field", {8'h0, m[1][31:8]}, {8'h0, HEADER_CLASS_FIELD});
    endtask
    task automatic ph(logic [3:0] c, logic [31:0] ad);
        logic [11:0] e;
        u_mst.phase(c, ad);
        e = exp_ev(c, ad);
        #1;
        chk_ev("window", {3'h0, e[11]}, {3'h0, SYSMGMT_IO_HIT});
        chk_ev("serial", {2'h0, e[10:9]}, {2'h0, SERIAL_TRAP_EVENT});
        chk_ev("audio", {3'h0, e[8]}, {3'h0, AUDIO_TRAP_EVENT});
        chk_ev("card", {2'h0, e[7:6]}, {2'h0, CARD_TRAP_EVENT});
        chk_ev("io_range", e[5:2], IO_RANGE_EVENT);
        chk_ev("mem_range", {2'h0, e[1:0]}, {2'h0, MEM_RANGE_EVENT});
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // A hang shows up as a stuck run; 30000 cycles is several times the expected length.
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        for (int i = 0; i < NREG; i++) m[i] = REG_RST[i];
        repeat (6) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        @(posedge SYS_CLK);
        for (int i = 0; i < NREG; i++) rd(REG_OFF[i]);
        ph(CMD_IO_WRITE, 32'h000003f8);
        chk_ev("serial_walk", 4'h1, {2'h0, SERIAL_TRAP_EVENT});
        // Only the extension bit separates 0x500 from 0x300 once bits 10:8 are masked.
        wr(REG_OFF[R_IO_RANGE_ADDR_HIGH], 4'hf, 32'h00000300);
        x3 <= 1'b1;
        ph(CMD_IO_READ, 32'h00000500);
        chk_ev("range3_ext", 4'h4, IO_RANGE_EVENT);
        @(posedge SYS_CLK);
        x3 <= 1'b0;
        ph(CMD_IO_READ, 32'h00000500);
        chk_ev("range3_plain", 4'h0, IO_RANGE_EVENT);
        for (int k = 0; k < 400; k++) begin
            r = rnd();
            d = rnd();
            wr((r[4:0] % 18 == 17) ? 8'he0 : REG_OFF[r[4:0] % 18], r[11:8], d);
            rd((r[4:0] % 18 == 17) ? 8'he0 : REG_OFF[r[4:0] % 18]);
            @(posedge SYS_CLK);
            {en, x3, x4} <= r[14:12];
            repeat (4) begin
                a = rnd();
                r = rnd();
                d = m[r[3:0] % NREG];
                if (r[4]) a[15:0] = r[5] ? d[31:16] : d[15:0];
                if (r[6]) a[31:8] = d[31:8];
                ph(cmds[r[10:8]], a);
            end
        end
        // A second reset in mid-run must bring every register back to its default.
        @(posedge SYS_CLK);
        RSTN <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        for (int i = 0; i < NREG; i++) m[i] = REG_RST[i];
        @(posedge SYS_CLK);
        for (int i = 0; i < NREG; i++) rd(REG_OFF[i]);
        print_verdict;
    end
endmodule
